//--- core/srs_dev.sv
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - Device is always slave; master clocks transfers.
// - Data output floats except while returning data.
// - Bit order register bits 3,4 choose order.
// - Bit order resets to most significant first.
// - Polarity pin gives the idle clock level.
// - Phase zero: capture leading, change trailing.
// - Phase one: capture trailing, change next leading.
// - Clock may stop while chip select high.
// - Control word: direction, 14 address bits, burst.
// - Direction one reads; burst one increments address.
// - Low-first order reverses the address bits.
// - Single write: control word, byte, deselect.
// - Single read: control word, device returns byte.
// - Burst write stores each byte, then increments.
// - Burst read outputs, increments, prefetches next byte.
// - Burst address wraps from top to zero.
// - Chip select rise resets the serial logic.
// - Partial write byte is discarded.
// - Master releases shared line while device returns.
// - Software reset leaves the serial port alone.
module srs_dev
	import srs_pkg::*;
(
	input  wire logic                   i_clk,
	input  wire logic                   i_rst_n,
	input  wire logic                   i_ce,
	srs_spi_if.dev                      spi,
	output logic [srs_pkg::ADDR_W-1:0]  o_reg_addr,
	output logic [7:0]                  o_reg_wdata,
	output logic                        o_reg_wr,
	output logic                        o_reg_rd,
	input  wire logic [7:0]             i_reg_rdata,
	output logic                        o_lsb_first
);
	import srs_pkg::*;

	// All state of the device end.
	typedef struct packed {
		srs_dev_state_t     ph;      // Transfer phase.
		logic               sclk_q;  // Serial clock seen one cycle ago.
		logic [3:0]         bitcnt;  // Bits captured in this unit.
		logic [2:0]         ocnt;    // Bits sent in this byte.
		logic [15:0]        sh;      // Capture shift register.
		logic [ADDR_W-1:0]  addr;    // Internal address counter.
		logic               burst;   // Burst access in progress.
		logic [7:0]         bitord;  // Bit order register.
		logic [7:0]         pre;     // Prefetched read byte.
		logic [7:0]         tx;      // Output shift register.
		logic               sdo;     // Serial output bit.
		logic               sdo_oe;  // Serial output drive enable.
		logic [ADDR_W-1:0]  raddr;   // Address shown to the registers.
		logic [7:0]         wdata;   // Write byte shown to the registers.
		logic               wr;      // Register write pulse.
		logic               rd;      // Register read pulse.
		logic               rd_q;    // Read data arrives this cycle.
		logic               int_rd;  // Read targets the bit order register.
	} srs_dev_st_t;

	srs_dev_st_t       st;       // Present state.
	srs_dev_st_t       next_st;  // Next state.
	logic [4:0]        pins;     // Synchronised link pins.
	logic              cs_s;     // Chip select after synchronising.
	logic              sclk_s;   // Serial clock after synchronising.
	logic              sdi_s;    // Serial input after synchronising.
	logic              cpol_s;   // Polarity strap after synchronising.
	logic              cpha_s;   // Phase strap after synchronising.

	// Every pin passes two flip-flops; the serial clock is only sampled,
	// so register requests are born in the system clock domain.
	srs_sync #(
		.W (5)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_d     ({spi.cs_n, spi.sclk, spi.sdi_line, spi.cpol, spi.cpha}),
		.o_q     (pins)
	);

	assign {cs_s, sclk_s, sdi_s, cpol_s, cpha_s} = pins;

	// Next state: edge finding, capture, output and register requests.
	always_comb
	begin
		logic              edge_seen; // Serial clock changed level.
		logic              lead;      // Clock left its idle level.
		logic              trail;     // Clock returned to its idle level.
		logic              cap;       // Capture edge.
		logic              chg;       // Output change edge.
		logic              lsb;       // Least significant bit first.
		logic [15:0]       word;      // Shift register with the new bit.
		logic [ADDR_W-1:0] a;         // Decoded address.
		logic [7:0]        b;         // Decoded byte.
		logic [7:0]        t;         // Byte being loaded for output.
		edge_seen = 1'b0;
		lead      = 1'b0;
		trail     = 1'b0;
		cap       = 1'b0;
		chg       = 1'b0;
		lsb       = 1'b0;
		word      = '0;
		a         = '0;
		b         = '0;
		t         = '0;
		next_st        = st;
		next_st.wr     = 1'b0;
		next_st.rd     = 1'b0;
		next_st.rd_q   = st.rd;
		next_st.sclk_q = sclk_s;
		// Leading edge leaves the idle level set by the polarity pin.
		edge_seen = sclk_s != st.sclk_q;
		lead      = edge_seen && (sclk_s != cpol_s);
		trail     = edge_seen && (sclk_s == cpol_s);
		// Phase zero captures on leading edges, phase one on trailing.
		cap = cpha_s ? trail : lead;
		chg = cpha_s ? lead : trail;
		// Either order bit set selects least significant bit first.
		lsb  = st.bitord[BITORD_LSB_A] | st.bitord[BITORD_LSB_B];
		word = {st.sh[14:0], sdi_s};
		// Catch the read byte one cycle after the read pulse.
		if (st.rd_q)
		begin
			next_st.pre = st.int_rd ? st.bitord : i_reg_rdata;
		end
		if (cs_s)
		begin
			// Deselected: drop any partial unit and float the output.
			// Edges while deselected are ignored, so a stopped or running
			// clock does not matter here.
			next_st.ph     = SRS_D_IDLE;
			next_st.bitcnt = '0;
			next_st.ocnt   = '0;
			next_st.sdo_oe = 1'b0;
		end
		else
		begin
			unique case (st.ph)
				SRS_D_IDLE, SRS_D_CTRL:
				begin
					// The master opened the frame; collect the control word.
					next_st.ph = SRS_D_CTRL;
					if (cap)
					begin
						next_st.sh     = word;
						next_st.bitcnt = st.bitcnt + 4'h1;
						if (st.bitcnt == 4'(CTRL_BITS - 1))
						begin
							// Direction first, address, then burst.
							next_st.bitcnt = '0;
							next_st.burst  = word[CW_BURST];
							a = lsb ? srs_rev14(word[14:1])
								: word[14:1];
							next_st.addr = a;
							if (word[CW_RNW])
							begin
								// Read: fetch the first byte at once.
								next_st.ph     = SRS_D_RDATA;
								next_st.rd     = 1'b1;
								next_st.raddr  = a;
								next_st.int_rd = a == BITORD_ADDR;
							end
							else
							begin
								next_st.ph = SRS_D_WDATA;
							end
						end
					end
				end
				SRS_D_WDATA:
				begin
					// A byte is only written once its last bit is captured.
					if (cap)
					begin
						next_st.sh     = word;
						next_st.bitcnt = st.bitcnt + 4'h1;
						if (st.bitcnt == 4'(BYTE_BITS - 1))
						begin
							next_st.bitcnt = '0;
							b = lsb ? srs_rev8(word[7:0]) : word[7:0];
							if (st.addr == BITORD_ADDR)
							begin
								next_st.bitord = b;
							end
							else
							begin
								next_st.wr    = 1'b1;
								next_st.raddr = st.addr;
								next_st.wdata = b;
							end
							// Step on, wrapping at the top.
							next_st.addr = st.addr + 14'h0001;
							if (!st.burst)
							begin
								next_st.ph = SRS_D_DONE;
							end
						end
					end
				end
				SRS_D_RDATA:
				begin
					if (chg)
					begin
						if (st.ocnt == 3'h0)
						begin
							// Load the fetched byte and start driving.
							t = lsb ? srs_rev8(st.pre) : st.pre;
							next_st.sdo    = t[7];
							next_st.tx     = {t[6:0], 1'b0};
							next_st.sdo_oe = 1'b1;
							if (st.burst)
							begin
								// Step and prefetch.
								next_st.addr   = st.addr + 14'h0001;
								next_st.rd     = 1'b1;
								next_st.raddr  = st.addr + 14'h0001;
								next_st.int_rd =
									(st.addr + 14'h0001) == BITORD_ADDR;
							end
						end
						else
						begin
							next_st.sdo = st.tx[7];
							next_st.tx  = {st.tx[6:0], 1'b0};
						end
						next_st.ocnt = st.ocnt + 3'h1;
					end
					if (cap)
					begin
						next_st.bitcnt = st.bitcnt + 4'h1;
						if (st.bitcnt == 4'(BYTE_BITS - 1))
						begin
							next_st.bitcnt = '0;
							if (!st.burst)
							begin
								// Single read ends; release the line.
								next_st.ph     = SRS_D_DONE;
								next_st.sdo_oe = 1'b0;
							end
						end
					end
				end
				SRS_D_DONE:
				begin
					// Wait for the master to deselect.
					next_st.sdo_oe = 1'b0;
				end
				default:
				begin
					next_st.ph = SRS_D_IDLE;
				end
			endcase
		end
	end

	// Only the reset pin clears this state; no software reset reaches the
	// serial port or its bit order register.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st        <= '0;
			st.ph     <= SRS_D_IDLE;
			st.bitord <= BITORD_RST;
		end
		else if (i_ce)
		begin
			st <= next_st;
		end
	end

	// Outputs come straight from the state register.
	assign spi.sdo     = st.sdo;
	assign spi.sdo_oe  = st.sdo_oe;
	assign o_reg_addr  = st.raddr;
	assign o_reg_wdata = st.wdata;
	assign o_reg_wr    = st.wr;
	assign o_reg_rd    = st.rd;
	assign o_lsb_first = st.bitord[BITORD_LSB_A] | st.bitord[BITORD_LSB_B];
endmodule : srs_dev

//--- core/srs_host.sv
`timescale 1ns/1ps
// Serial bus master controlled through an Avalon-MM register slave.
module srs_host
	import srs_pkg::*;
#(
	parameter logic [7:0] HALF = srs_pkg::HALF_CLKS
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	srs_spi_if.host          spi,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest
);
	import srs_pkg::*;

	// All state of the host end.
	typedef struct packed {
		srs_host_state_t ph;     // Transfer phase.
		logic            cs_n;   // Chip select.
		logic            sclk;   // Serial clock.
		logic            mosi;   // Serial output bit.
		logic            oe;     // Serial output drive enable.
		logic [7:0]      cnt;    // Half period counter.
		logic [11:0]     o_idx;  // Bits sent.
		logic [11:0]     s_idx;  // Bits sampled.
		logic [11:0]     total;  // Bits in the frame.
		logic [15:0]     sh;     // Output shift register.
		logic [7:0]      rxsh;   // Input shift register.
		logic [7:0]      rx;     // Last received byte.
		logic            rx_full;// Received byte not yet read.
		logic [7:0]      tx;     // Next byte to send.
		logic            tx_full;// Next byte present.
		logic [31:0]     cmd;    // Command register.
		logic [2:0]      cfg;    // Configuration register.
		logic            ack;    // Bus answer cycle.
		logic [31:0]     rdata;  // Bus read data.
	} srs_host_st_t;

	srs_host_st_t st;      // Present state.
	srs_host_st_t next_st; // Next state.
	logic         miso_s;  // Device data after synchronising.

	// The returned data line passes two flip-flops before use.
	srs_sync #(
		.W (1)
	) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_d     (spi.sdo_line),
		.o_q     (miso_s)
	);

	// Next state: register slave, clock divider and shifting.
	always_comb
	begin
		logic        req;   // Bus request present.
		logic        lsb;   // Least significant bit first.
		logic        rnw;   // Transfer reads.
		logic        chg;   // This tick is an output change edge.
		logic        bstart;// Next output bit starts a data byte.
		logic        stall; // Next byte not ready.
		logic [15:0] v;     // Word to shift out.
		logic [7:0]  r;     // Received byte in arrival order.
		req    = i_avs_read | i_avs_write;
		lsb    = st.cfg[CFG_LSB];
		rnw    = st.cmd[CMD_RNW];
		chg    = (st.sclk == st.cfg[CFG_CPOL]) == st.cfg[CFG_CPHA];
		bstart = (st.o_idx >= 12'(CTRL_BITS)) && (st.o_idx < st.total)
			&& (st.o_idx[2:0] == 3'h0);
		stall  = bstart && (rnw ? st.rx_full : !st.tx_full);
		v      = st.sh;
		r      = {st.rxsh[6:0], miso_s};
		next_st     = st;
		next_st.ack = req && !st.ack;
		// Read data is ready in the answer cycle.
		if (req && !st.ack)
		begin
			unique case (i_avs_address)
				REG_CMD:  next_st.rdata = st.cmd;
				REG_CFG:  next_st.rdata = {29'h0, st.cfg};
				REG_DATA: next_st.rdata = {24'h0, st.rx};
				REG_STAT: next_st.rdata = {29'h0, st.rx_full, st.tx_full,
					st.ph != SRS_H_IDLE};
				default:  next_st.rdata = '0;
			endcase
		end
		// Reading the data register frees the receive byte.
		if (st.ack && i_avs_read && i_avs_address == REG_DATA)
		begin
			next_st.rx_full = 1'b0;
		end
		if (st.ack && i_avs_write)
		begin
			if (i_avs_address == REG_CFG)
			begin
				next_st.cfg = i_avs_writedata[2:0];
				// Park the clock at its new idle level while deselected.
				if (st.ph == SRS_H_IDLE)
				begin
					next_st.sclk = i_avs_writedata[CFG_CPOL];
				end
			end
			if (i_avs_address == REG_DATA)
			begin
				next_st.tx      = i_avs_writedata[7:0];
				next_st.tx_full = 1'b1;
			end
			if (i_avs_address == REG_CMD && st.ph == SRS_H_IDLE)
			begin
				// Start a frame: only the master begins transfers.
				next_st.cmd   = i_avs_writedata;
				next_st.ph    = SRS_H_RUN;
				next_st.cs_n  = 1'b0;
				next_st.sclk  = st.cfg[CFG_CPOL];
				next_st.cnt   = '0;
				next_st.o_idx = '0;
				next_st.s_idx = '0;
				next_st.total = 12'(CTRL_BITS) + {1'b0,
					i_avs_writedata[31:24], 3'h0} + 12'(BYTE_BITS);
				// Direction, address, burst bit.
				next_st.sh = {i_avs_writedata[CMD_RNW],
					st.cfg[CFG_LSB] ? srs_rev14(i_avs_writedata[13:0])
					: i_avs_writedata[13:0],
					i_avs_writedata[31:24] != 8'h00};
				next_st.oe = 1'b1;
				if (!st.cfg[CFG_CPHA])
				begin
					// Phase zero needs the first bit before the first edge.
					next_st.mosi  = next_st.sh[15];
					next_st.sh    = {next_st.sh[14:0], 1'b0};
					next_st.o_idx = 12'h001;
				end
			end
		end
		if (st.ph == SRS_H_RUN)
		begin
			if (st.cnt != HALF - 8'h01)
			begin
				next_st.cnt = st.cnt + 8'h01;
			end
			else if (st.s_idx == st.total && st.sclk == st.cfg[CFG_CPOL])
			begin
				// Frame complete with the clock idle: deselect.
				next_st.ph   = SRS_H_FIN;
				next_st.cs_n = 1'b1;
				next_st.oe   = 1'b0;
				next_st.cnt  = '0;
			end
			else if (!stall)
			begin
				next_st.sclk = !st.sclk;
				next_st.cnt  = '0;
				if (chg && st.o_idx < st.total)
				begin
					if (bstart && !rnw)
					begin
						v[15:8] = lsb ? srs_rev8(st.tx) : st.tx;
						// A byte written in this same cycle stays pending.
						next_st.tx_full = st.ack && i_avs_write
							&& i_avs_address == REG_DATA;
					end
					next_st.mosi  = v[15];
					next_st.sh    = {v[14:0], 1'b0};
					// Release the data line while the device answers.
					next_st.oe    = !(rnw && st.o_idx >= 12'(CTRL_BITS));
					next_st.o_idx = st.o_idx + 12'h001;
				end
				else if (!chg && st.s_idx < st.total)
				begin
					next_st.s_idx = st.s_idx + 12'h001;
					if (rnw && st.s_idx >= 12'(CTRL_BITS))
					begin
						next_st.rxsh = r;
						if (st.s_idx[2:0] == 3'h7)
						begin
							// A received byte wins over a clear.
							next_st.rx      = lsb ? srs_rev8(r) : r;
							next_st.rx_full = 1'b1;
						end
					end
				end
			end
		end
		else if (st.ph == SRS_H_FIN)
		begin
			// Keep chip select high for one half period.
			next_st.cnt = st.cnt + 8'h01;
			if (st.cnt == HALF - 8'h01)
			begin
				next_st.ph = SRS_H_IDLE;
			end
		end
	end

	// Register the state, frozen while the clock enable is low.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st      <= '0;
			st.ph   <= SRS_H_IDLE;
			st.cs_n <= 1'b1;
			st.cfg  <= CFG_RST;
		end
		else if (i_ce)
		begin
			st <= next_st;
		end
	end

	assign spi.cs_n          = st.cs_n;
	assign spi.sclk          = st.sclk;
	assign spi.sdi           = st.mosi;
	assign spi.sdi_oe        = st.oe;
	assign spi.cpol          = st.cfg[CFG_CPOL];
	assign spi.cpha          = st.cfg[CFG_CPHA];
	assign o_avs_readdata    = st.rdata;
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & !st.ack;
endmodule : srs_host

//--- core/srs_pkg.sv
package srs_pkg;

	// Serial frame shape.
	localparam int          CTRL_BITS    = 16;
	localparam int          BYTE_BITS    = 8;
	localparam int          ADDR_W       = 14;
	// Bit order register and its reset value (most significant bit first).
	localparam logic [13:0] BITORD_ADDR  = 14'h3FFF;
	localparam logic [7:0]  BITORD_RST   = 8'h00;
	localparam int          BITORD_LSB_A = 3;
	localparam int          BITORD_LSB_B = 4;
	// Positions inside the control word; the first bit to arrive is bit 15.
	localparam int          CW_RNW       = 15;
	localparam int          CW_BURST     = 0;
	// Controller register byte offsets on the Avalon-MM slave.
	localparam logic [3:0]  REG_CMD      = 4'h0;
	localparam logic [3:0]  REG_CFG      = 4'h4;
	localparam logic [3:0]  REG_DATA     = 4'h8;
	localparam logic [3:0]  REG_STAT     = 4'hC;
	// Command register fields.
	localparam int          CMD_RNW      = 16;
	localparam int          CMD_CNT_LSB  = 24;
	// Configuration register fields and reset value.
	localparam int          CFG_CPOL     = 0;
	localparam int          CFG_CPHA     = 1;
	localparam int          CFG_LSB      = 2;
	localparam logic [2:0]  CFG_RST      = 3'h0;
	// System clock cycles per half serial clock period made by the host.
	localparam logic [7:0]  HALF_CLKS    = 8'h08;

	// Device end transfer phases.
	typedef enum logic [2:0]
	{
		SRS_D_IDLE  = 3'b000,
		SRS_D_CTRL  = 3'b001,
		SRS_D_WDATA = 3'b010,
		SRS_D_RDATA = 3'b011,
		SRS_D_DONE  = 3'b100
	} srs_dev_state_t;

	// Host end transfer phases.
	typedef enum logic [1:0]
	{
		SRS_H_IDLE = 2'b00,
		SRS_H_RUN  = 2'b01,
		SRS_H_FIN  = 2'b10
	} srs_host_state_t;

	// Reverses a byte.
	function automatic logic [7:0] srs_rev8(input logic [7:0] v);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++)
			r[i] = v[7-i];
		return r;
	endfunction : srs_rev8

	// Reverses a register address.
	function automatic logic [13:0] srs_rev14(input logic [13:0] v);
		logic [13:0] r;
		r = '0;
		for (int i = 0; i < 14; i++)
			r[i] = v[13-i];
		return r;
	endfunction : srs_rev14

endpackage : srs_pkg

//--- core/srs_spi_if.sv
`timescale 1ns/1ps
// Serial link between the register slave port and its bus master.
interface srs_spi_if;
	logic cs_n;     // Chip select, low while a transfer runs.
	logic sclk;     // Serial clock made by the master.
	logic sdi;      // Master data toward the device.
	logic sdi_oe;   // Master drives the data line while high.
	logic sdo;      // Device data toward the master.
	logic sdo_oe;   // Device drives its data line while high.
	logic cpol;     // Clock polarity strap.
	logic cpha;     // Clock phase strap.
	wire  sdi_line; // Resolved master data line.
	wire  sdo_line; // Resolved device data line.

	// A released line rests at its pull-up level, high.
	assign sdi_line = sdi_oe ? sdi : 1'b1;
	assign sdo_line = sdo_oe ? sdo : 1'b1;

	modport dev
	(
		input  cs_n, sclk, sdi_line, cpol, cpha,
		output sdo, sdo_oe
	);
	modport host
	(
		output cs_n, sclk, sdi, sdi_oe, cpol, cpha,
		input  sdo_line
	);
endinterface : srs_spi_if

//--- core/srs_sync.sv
`timescale 1ns/1ps
// Two flip-flop synchroniser for levels arriving from outside the clock.
module srs_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	// Both stages of the chain.
	typedef struct packed {
		logic [W-1:0] s1; // First stage, read only by the second.
		logic [W-1:0] s2; // Second stage, safe to use.
	} srs_sync_st_t;

	srs_sync_st_t st;      // Present state.
	srs_sync_st_t next_st; // Next state.

	// Shift the input down the chain.
	always_comb
	begin
		next_st.s1 = i_d;
		next_st.s2 = st.s1;
	end

	// Register the chain, frozen while the clock enable is low.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st <= '0;
		else if (i_ce)
			st <= next_st;
	end

	assign o_q = st.s2;
endmodule : srs_sync

//--- verif/srs_link_sva.sv
`timescale 1ns/1ps
// Watches the link that joins the two ends.
module srs_link_sva
(
	input wire logic i_clk,   // System clock.
	input wire logic i_rst_n, // Reset, low active.
	input wire logic cs_n,    // Chip select.
	input wire logic sclk,    // Serial clock.
	input wire logic sdi,     // Master data.
	input wire logic sdi_oe,  // Master drive enable.
	input wire logic sdo,     // Device data.
	input wire logic sdo_oe,  // Device drive enable.
	input wire logic cpol,    // Polarity strap.
	input wire logic cpha     // Phase strap.
);
	logic       sclk_q; // Serial clock one cycle ago.
	logic [7:0] cnt;    // Capture edges in this frame.
	logic       cap;    // Capture edge in this cycle.

	// The phase strap picks which edge of a pulse captures.
	assign cap = !cs_n && sclk != sclk_q && (sclk ^ cpol) != cpha;

	// Counts capture edges and clears the count between frames.
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sclk_q <= 1'b0;
			cnt    <= 8'h00;
		end
		else
		begin
			sclk_q <= sclk;
			cnt    <= cs_n ? 8'h00 : cnt + {7'h00, cap};
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	property p_idle; cs_n [*8] |-> !sdo_oe; endproperty
	a_idle: assert property (p_idle)
		else $error("Output driven while deselected.");
	property p_oe_on; $rose(sdo_oe) |-> cnt == 8'h10; endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("Output enabled at wrong bit.");
	property p_oe_off; $fell(sdo_oe) |-> cs_n || cnt == 8'h18; endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("Output released at wrong bit.");
	property p_sdo_hold;
		cap && sdo_oe |=> (!sdo_oe || $stable(sdo)) [*6];
	endproperty
	a_sdo_hold: assert property (p_sdo_hold)
		else $error("Device data moved near capture.");
	property p_sdi_hold; cap && sdi_oe |-> $stable(sdi); endproperty
	a_sdi_hold: assert property (p_sdi_hold)
		else $error("Master data moved at capture.");
	property p_clash; sdo_oe |-> !sdi_oe; endproperty
	a_clash: assert property (p_clash)
		else $error("Both ends drive data.");
	property p_lvl; $fell(cs_n) || $rose(cs_n) |-> sclk == cpol; endproperty
	a_lvl: assert property (p_lvl)
		else $error("Clock not at idle level.");
	property p_whole;
		$rose(cs_n) |-> cnt >= 8'h18 && cnt[2:0] == 3'h0;
	endproperty
	a_whole: assert property (p_whole)
		else $error("Frame not whole bytes.");
endmodule : srs_link_sva

//--- verif/srs_tb.sv
`timescale 1ns/1ps
// Runs both ends against a register model.
module srs_tb;
	import srs_pkg::*;
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin fails++; \
	$display("Error %0t: got %h want %h", $time, g, w); end end
	logic        i_clk = 1'b0;   // System clock.
	logic        i_rst_n = 1'b0; // Reset, low active.
	logic        h_rst_n = 1'b1; // Host end reset, low active.
	logic [3:0]  av_a = 4'h0;    // Bus address.
	logic        av_rd = 1'b0;   // Bus read.
	logic        av_wr = 1'b0;   // Bus write.
	logic [31:0] av_wd = 32'h0;  // Bus write data.
	logic [31:0] av_q;           // Bus read data.
	logic        av_wait;        // Bus stall.
	logic [13:0] ra;             // Register address.
	logic [7:0]  rwd;            // Register write data.
	logic [7:0]  rrd = 8'h00;    // Register read data.
	logic        rwr, rrq, lsbf; // Strobes and bit order.
	logic [7:0]  regs [0:16383]; // Registers behind the device.
	logic [7:0]  expm [0:16383]; // Expected contents.
	logic [15:0] cw;             // Control word on the link.
	logic [7:0]  sh;             // Last byte on the link.
	logic        sq = 1'b0;      // Serial clock one cycle ago.
	int          bc, fails, checks_done;

	srs_spi_if lnk ();
	srs_host srs_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n & h_rst_n),
		.i_ce(1'b1),
		.spi(lnk), .i_avs_address(av_a), .i_avs_read(av_rd),
		.i_avs_write(av_wr), .i_avs_writedata(av_wd),
		.o_avs_readdata(av_q), .o_avs_waitrequest(av_wait));
	srs_dev srs_dev_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
		.spi(lnk), .o_reg_addr(ra), .o_reg_wdata(rwd), .o_reg_wr(rwr),
		.o_reg_rd(rrq), .i_reg_rdata(rrd), .o_lsb_first(lsbf));
	srs_link_sva srs_link_sva_i (.i_clk(i_clk),
		.i_rst_n(i_rst_n & h_rst_n),
		.cs_n(lnk.cs_n), .sclk(lnk.sclk), .sdi(lnk.sdi),
		.sdi_oe(lnk.sdi_oe), .sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe),
		.cpol(lnk.cpol), .cpha(lnk.cpha));

	always #20 i_clk = ~i_clk;

	// Register file: writes land at once, reads answer a cycle later.
	always @(posedge i_clk)
	begin
		if (rwr)
			regs[ra] <= rwd;
		// Data only answers a read strobe; otherwise it shows the inverse.
		rrd <= rrq ? regs[ra] : ~regs[ra];
	end

	// Collects captured bits; the first sixteen are the control word.
	always @(negedge i_clk)
	begin
		sq <= lnk.sclk;
		if (lnk.cs_n)
			bc <= 0;
		else if (lnk.sclk !== sq && (lnk.sclk ^ lnk.cpol) !== lnk.cpha)
		begin
			bc <= bc + 1;
			if (bc < 16)
				cw <= {cw[14:0], lnk.sdi_line};
			else
				sh <= {sh[6:0], lnk.sdo_oe ? lnk.sdo_line : lnk.sdi_line};
		end
	end

	// Prints the verdict and stops.
	task automatic tally_and_finish;
		if (fails == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish

	// Ends the run when a wait used up its bound.
	task automatic limit(input int n, input int lim);
		if (n >= lim)
		begin
			fails++;
			$display("Error %0t: wait timed out", $time);
			tally_and_finish();
		end
	endtask : limit

	// One bus cycle, held until the stall drops.
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge i_clk);
		av_a  <= a;
		av_wr <= w;
		av_rd <= !w;
		av_wd <= d;
		// Waitrequest and read data are both taken at the rising edge.
		for (n = 0; n < 50; n++)
		begin
			@(posedge i_clk);
			if (av_wait === 1'b0)
				break;
		end
		limit(n, 50);
		q = av_q;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
	endtask : av

	// Reads status until bit b shows v.
	task automatic poll(input int b, input logic v);
		logic [31:0] q;
		int          n;
		q = {32{~v}};
		for (n = 0; n < 4000 && q[b] !== v; n++)
			av(1'b0, REG_STAT, 32'h0, q);
		limit(n, 4000);
	endtask : poll

	// One frame of n bytes; v is the byte stored at the top address.
	task automatic xfer(input logic rnw, input int a, input int n,
		input logic lm, input logic [1:0] md, input logic [7:0] v);
		logic [31:0] q, cmd;
		logic [13:0] aw, ar;
		logic [7:0]  d, dr;
		int          x;
		aw = 14'(a);
		ar = {<<{aw}};
		d = 8'h00;
		cmd = {8'(n - 1), 7'h00, rnw, 2'h0, aw};
		av(1'b1, REG_CFG, {29'h0, lm, md}, q);
		if (rnw)
			av(1'b1, REG_CMD, cmd, q);
		for (int i = 0; i < n; i++)
		begin
			x = (a + i) % 16384;
			if (rnw)
			begin
				poll(2, 1'b1);
				av(1'b0, REG_DATA, 32'h0, q);
				d = expm[x];
				`CHK(q[7:0], d)
			end
			else
			begin
				d = (x == 16383) ? v : 8'($urandom);
				expm[x] = d;
				if (i > 0)
					poll(1, 1'b0);
				av(1'b1, REG_DATA, {24'h0, d}, q);
				if (i == 0)
					av(1'b1, REG_CMD, cmd, q);
			end
		end
		poll(0, 1'b0);
		dr = {<<{d}};
		`CHK(cw, {rnw, lm ? ar : aw, n > 1})
		`CHK(sh, lm ? dr : d)
		`CHK(lsbf, expm[16383][3] | expm[16383][4])
		for (int i = 0; i < n; i++)
			if ((a + i) % 16384 != 16383)
				`CHK(regs[(a + i) % 16384], expm[(a + i) % 16384])
	endtask : xfer

	// Main sequence: every clock mode in both orders, bursts over the wrap.
	initial
	begin
		int          a;
		logic [31:0] q;
		void'($urandom(32'hF742));
		for (int i = 0; i < 16384; i++)
			regs[i] = 8'($urandom);
		expm = regs;
		expm[16383] = BITORD_RST;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		xfer(1'b1, 16383, 1, 1'b0, 2'h0, 8'h00);
		for (int m = 0; m < 4; m++)
		begin
			a = $urandom_range(16382);
			xfer(1'b0, a, 1, 1'b0, 2'(m), 8'h00);
			xfer(1'b1, a, 1, 1'b0, 2'(m), 8'h00);
		end
		// A host reset cuts a write frame inside its data byte.
		a = $urandom_range(16382);
		av(1'b1, REG_DATA, {24'h0, ~expm[a]}, q);
		av(1'b1, REG_CMD, 32'(a), q);
		repeat (300) @(posedge i_clk);
		h_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		h_rst_n <= 1'b1;
		repeat (20) @(posedge i_clk);
		`CHK(regs[a], expm[a])
		xfer(1'b0, 16382, 3, 1'b0, 2'h1, 8'h07);
		xfer(1'b1, 16382, 3, 1'b0, 2'h2, 8'h00);
		xfer(1'b0, 16383, 1, 1'b0, 2'h3, 8'h10);
		for (int m = 0; m < 4; m++)
		begin
			a = $urandom_range(16383);
			xfer(1'b0, a, 2, 1'b1, 2'(m), 8'h08);
			xfer(1'b1, a, 2, 1'b1, 2'(m), 8'h00);
		end
		// A second reset must bring back most significant bit first.
		i_rst_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		expm[16383] = BITORD_RST;
		xfer(1'b1, 16383, 1, 1'b0, 2'h0, 8'h00);
		tally_and_finish();
	end
endmodule : srs_tb
